//--- logic/pit_pkg.sv
// What this block does
// - three identical independent channels, each may run its own mode.
// - each channel counts down in 16 bits, stepped by its own clock pin.
// - output latch follows count; latch command freezes it until read.
// - reads come from the output latch only, one byte at a time.
// - count writes fill a two-byte staging register; both bytes load together.
// - a control word that is not a latch command clears the channel's staging register.
// - the counting element is loaded only from the staging register.
// - port select 11 with chip select writes the control word port.
// - top two control bits pick channel 0..2; 11 is read-back.
// - bits 5..4 pick latch command, low only, high only, low then high.
// - count bytes go to the addressed channel per its held format.
// - mode, count and output reset to zero; only the mode holds zero until software programs it.
// - strobes act only with chip select low; ports 00,01,10 are channels.
package pit_pkg;
    localparam int          PIT_NUM_CH      = 3;
    localparam logic [1:0]  PIT_PORT_CTRL   = 2'h3;
    // ------------------------------------------------------------
    // control word field positions
    // ------------------------------------------------------------
    localparam int          PIT_CW_CH_HI    = 7;
    localparam int          PIT_CW_CH_LO    = 6;
    localparam int          PIT_CW_FMT_HI   = 5;
    localparam int          PIT_CW_FMT_LO   = 4;
    localparam int          PIT_CW_MODE_HI  = 3;
    localparam int          PIT_CW_MODE_LO  = 1;
    localparam int          PIT_CW_BCD      = 0;
    localparam int          PIT_CW_MODE_PER = 2;
    localparam logic [1:0]  PIT_CH_READBACK = 2'h3;
    // ------------------------------------------------------------
    // access formats and reset values
    // ------------------------------------------------------------
    localparam logic [1:0]  PIT_FMT_LATCH   = 2'h0;
    localparam logic [1:0]  PIT_FMT_LOW     = 2'h1;
    localparam logic [1:0]  PIT_FMT_HIGH    = 2'h2;
    localparam logic [1:0]  PIT_FMT_BOTH    = 2'h3;
    localparam logic [15:0] PIT_COUNT_RST   = 16'h0000;
    localparam logic [2:0]  PIT_MODE_RST    = 3'h0;
    localparam logic [1:0]  PIT_FMT_RST     = 2'h1;
    localparam logic [7:0]  PIT_DATA_RST    = 8'h00;
endpackage

//--- logic/pit_count_elem.sv
`timescale 1ns/1ps
`default_nettype none
module pit_count_elem
    import pit_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst_b,
    input  wire logic             i_load,
    input  wire logic [WIDTH-1:0] i_load_val,
    input  wire logic             i_bcd,
    input  wire logic             i_cnt_clk,
    input  wire logic             i_gate,
    output logic      [WIDTH-1:0] o_count,
    output logic                  o_out
);
    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic             pin;
        logic             out;
    } pit_ce_t;

    pit_ce_t st_q;
    pit_ce_t st_d;

    // decade-wise decrement; each nibble wraps 0 -> 9
    function automatic logic [WIDTH-1:0] bcd_dec(input logic [WIDTH-1:0] v);
        logic [WIDTH-1:0] r;
        logic             borrow;
        r = v;
        borrow = 1'b1;
        for (int n = 0; n < WIDTH / 4; n++) begin
            if (borrow) begin
                if (v[n*4 +: 4] == 4'h0) begin
                    r[n*4 +: 4] = 4'h9;
                end else begin
                    r[n*4 +: 4] = v[n*4 +: 4] - 4'h1;
                    borrow = 1'b0;
                end
            end
        end
        return r;
    endfunction

    always_comb begin
        st_d     = st_q;
        st_d.pin = i_cnt_clk;
        if (i_load) begin
            st_d.count = i_load_val;
            st_d.out   = 1'b0;
        end else if (i_cnt_clk && !st_q.pin && i_gate) begin
            // the channel pin is a plain input, so a rising edge is one step
            st_d.count = i_bcd ? bcd_dec(st_q.count) : st_q.count - WIDTH'(1);
            if (st_q.count == {{(WIDTH-1){1'b0}}, 1'b1}) begin
                st_d.out = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            // count, pin and output reset to zero; the element counts gated clock edges before software programs the channel
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_count = st_q.count;
    assign o_out   = st_q.out;
endmodule
`default_nettype wire

//--- logic/pit_counter_path.sv
`timescale 1ns/1ps
`default_nettype none
module pit_counter_path
    import pit_pkg::*;
#(
    parameter int NUM_CH = PIT_NUM_CH,
    parameter int WIDTH  = 16
) (
    input  wire logic              i_clk,
    input  wire logic              i_rst_b,
    input  wire logic              i_cs_b,
    input  wire logic              i_rd_b,
    input  wire logic              i_wr_b,
    input  wire logic [1:0]        i_port_select_lines,
    input  wire logic [7:0]        i_data,
    output logic      [7:0]        o_data,
    output logic                   o_data_oe_b,
    input  wire logic [NUM_CH-1:0] i_cnt_clk,
    input  wire logic [NUM_CH-1:0] i_gate,
    output logic      [NUM_CH-1:0] o_cnt_out,
    output logic      [NUM_CH*3-1:0] o_mode
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [NUM_CH-1:0][2:0]       mode;
        logic [NUM_CH-1:0][1:0]       fmt;
        logic [NUM_CH-1:0]            bcd;
        logic [NUM_CH-1:0][WIDTH-1:0] count_register;
        logic [NUM_CH-1:0][WIDTH-1:0] output_latch;
        logic [NUM_CH-1:0]            latched;
        logic [NUM_CH-1:0]            wr_ptr_hi;
        logic [NUM_CH-1:0]            rd_ptr_hi;
        logic [NUM_CH-1:0]            load;
        logic                         wr_seen;
        logic                         rd_seen;
        logic                         rd_live;
        logic [7:0]                   dout;
    } pit_path_t;

    pit_path_t                    st_q;
    pit_path_t                    st_d;
    logic [NUM_CH-1:0][WIDTH-1:0] ce_count;
    logic                         rd_act;
    logic                         wr_act;
    logic                         rd_start;
    logic                         wr_start;
    logic [1:0]                   cw_ch;
    logic [1:0]                   cw_fmt;
    logic [2:0]                   cw_mode;
    logic                         cw_bcd;
    logic                         cw_wr;
    logic                         cnt_wr;
    int unsigned                  sel;

    // ------------------------------------------------------------
    // counting elements
    // ------------------------------------------------------------
    // one element per channel, so modes and counts never interact
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        pit_count_elem #(
            .WIDTH      (WIDTH)
        ) u_ce (
            .i_clk      (i_clk),
            .i_rst_b    (i_rst_b),
            .i_load     (st_q.load[c]),
            .i_load_val (st_q.count_register[c]),
            .i_bcd      (st_q.bcd[c]),
            .i_cnt_clk  (i_cnt_clk[c]),
            .i_gate     (i_gate[c]),
            .o_count    (ce_count[c]),
            .o_out      (o_cnt_out[c])
        );
        assign o_mode[c*3 +: 3] = st_q.mode[c];
    end

    // ------------------------------------------------------------
    // strobe decode
    // ------------------------------------------------------------
    // strobes count only with chip select low; a new access starts on the
    // first cycle a qualified strobe is seen, so a long strobe acts once
    assign rd_act   = !i_cs_b && !i_rd_b && (i_port_select_lines != PIT_PORT_CTRL);
    assign wr_act   = !i_cs_b && !i_wr_b;
    assign rd_start = rd_act && !st_q.rd_seen;
    assign wr_start = wr_act && !st_q.wr_seen;
    assign cw_wr    = wr_start && (i_port_select_lines == PIT_PORT_CTRL);
    assign cnt_wr   = wr_start && (i_port_select_lines != PIT_PORT_CTRL);
    assign sel      = 32'(i_port_select_lines);

    // ------------------------------------------------------------
    // control word fields
    // ------------------------------------------------------------
    assign cw_ch    = i_data[PIT_CW_CH_HI:PIT_CW_CH_LO];
    assign cw_fmt   = i_data[PIT_CW_FMT_HI:PIT_CW_FMT_LO];
    assign cw_bcd   = i_data[PIT_CW_BCD];

    always_comb begin
        cw_mode = i_data[PIT_CW_MODE_HI:PIT_CW_MODE_LO];
        // periodic modes ignore the top mode bit; store the canonical code
        if (cw_mode[1]) begin
            cw_mode[PIT_CW_MODE_PER] = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_d         = st_q;
        st_d.load    = '0;
        st_d.wr_seen = wr_act;
        st_d.rd_seen = rd_act;
        st_d.rd_live = rd_act && (st_q.rd_live || rd_start);

        // a frozen latch ignores the element until its last byte is read
        for (int c = 0; c < NUM_CH; c++) begin
            if (!st_q.latched[c]) begin
                st_d.output_latch[c] = ce_count[c];
            end
        end

        // ------------------------------------------------------------
        // read path
        // ------------------------------------------------------------
        // reads are decoded before writes so that a latch command landing in
        // the same cycle as the closing read still wins; a read and a write
        // at once only come from a misbehaving host
        if (rd_start) begin
            unique case (st_q.fmt[sel])
                PIT_FMT_LOW: begin
                    st_d.dout         = st_q.output_latch[sel][7:0];
                    st_d.latched[sel] = 1'b0;
                end
                PIT_FMT_HIGH: begin
                    st_d.dout         = st_q.output_latch[sel][15:8];
                    st_d.latched[sel] = 1'b0;
                end
                PIT_FMT_BOTH: begin
                    if (st_q.rd_ptr_hi[sel]) begin
                        st_d.dout         = st_q.output_latch[sel][15:8];
                        st_d.latched[sel] = 1'b0;
                    end else begin
                        st_d.dout = st_q.output_latch[sel][7:0];
                    end
                    st_d.rd_ptr_hi[sel] = !st_q.rd_ptr_hi[sel];
                end
                default: begin
                    st_d.dout = PIT_DATA_RST;
                end
            endcase
        end

        // ------------------------------------------------------------
        // write path
        // ------------------------------------------------------------
        if (cw_wr) begin
            if (cw_ch != PIT_CH_READBACK) begin
                if (cw_fmt == PIT_FMT_LATCH) begin
                    // a second latch before the read is ignored
                    st_d.latched[cw_ch] = 1'b1;
                end else begin
                    st_d.fmt[cw_ch]            = cw_fmt;
                    st_d.mode[cw_ch]           = cw_mode;
                    st_d.bcd[cw_ch]            = cw_bcd;
                    st_d.count_register[cw_ch] = PIT_COUNT_RST;
                    st_d.wr_ptr_hi[cw_ch]      = 1'b0;
                    st_d.rd_ptr_hi[cw_ch]      = 1'b0;
                    st_d.latched[cw_ch]        = 1'b0;
                end
            end
            // read-back is decoded here and left without effect
        end else if (cnt_wr) begin
            unique case (st_q.fmt[sel])
                PIT_FMT_LOW: begin
                    st_d.count_register[sel][7:0] = i_data;
                    st_d.load[sel]                = 1'b1;
                end
                PIT_FMT_HIGH: begin
                    st_d.count_register[sel][15:8] = i_data;
                    st_d.load[sel]                 = 1'b1;
                end
                PIT_FMT_BOTH: begin
                    // the element reloads only once both bytes are in, never on half a count
                    if (st_q.wr_ptr_hi[sel]) begin
                        st_d.count_register[sel][15:8] = i_data;
                        st_d.load[sel]                 = 1'b1;
                    end else begin
                        st_d.count_register[sel][7:0] = i_data;
                    end
                    st_d.wr_ptr_hi[sel] = !st_q.wr_ptr_hi[sel];
                end
                default: begin
                    // latch code is never stored as a format
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            st_q         <= '0;
            st_q.fmt     <= {NUM_CH{PIT_FMT_RST}};
            // strobes still low at release count as already seen, so they never act
            st_q.wr_seen <= 1'b1;
            st_q.rd_seen <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // data pins
    // ------------------------------------------------------------
    // the byte is registered at strobe start, so the pins are driven from the
    // second strobe cycle on; hosts must hold the strobe at least two cycles.
    // a strobe already low when reset ends never started a read and stays mute
    assign o_data      = st_q.dout;
    assign o_data_oe_b = !(rd_act && st_q.rd_live);
endmodule
`default_nettype wire

//--- dv/pit_path_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module pit_path_monitor
    import pit_pkg::*;
#(
    parameter int NUM_CH = PIT_NUM_CH
) (
    input  wire logic                i_clk,
    input  wire logic                i_rst_b,
    input  wire logic                i_cs_b,
    input  wire logic                i_rd_b,
    input  wire logic                i_wr_b,
    input  wire logic [1:0]          i_port_select_lines,
    input  wire logic [7:0]          o_data,
    input  wire logic                o_data_oe_b,
    input  wire logic [NUM_CH-1:0]   i_cnt_clk,
    input  wire logic [NUM_CH-1:0]   o_cnt_out,
    input  wire logic [NUM_CH*3-1:0] o_mode
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    chk_idle_no_drive: assert property (i_rd_b |-> o_data_oe_b)
        else $error("data bus driven without a read strobe");
    chk_ctrl_port_mute: assert property (i_port_select_lines == PIT_PORT_CTRL
        && $past(i_port_select_lines) == PIT_PORT_CTRL |-> o_data_oe_b)
        else $error("control word port drove the data bus");
    chk_cs_mute: assert property (i_cs_b && $past(i_cs_b) |-> o_data_oe_b)
        else $error("data bus driven while deselected");
    chk_read_drive: assert property ($past(i_rd_b) && !i_rd_b && !i_cs_b
        && i_port_select_lines != PIT_PORT_CTRL ##1 !i_rd_b && !i_cs_b |-> !o_data_oe_b)
        else $error("counter read did not drive the bus");
    chk_mode_quiet: assert property (i_wr_b && $past(i_wr_b) && $past(i_wr_b, 2) |-> $stable(o_mode))
        else $error("mode changed without a write");
    chk_mode_periodic: assert property (!(o_mode[2] && o_mode[1]) && !(o_mode[5] && o_mode[4])
        && !(o_mode[8] && o_mode[7]))
        else $error("periodic mode stored with top bit set");
    chk_out_quiet: assert property (i_wr_b && $past(i_wr_b) && $past(i_wr_b, 2) && $past(i_wr_b, 3)
        && i_cnt_clk == '0 && $past(i_cnt_clk) == '0 && $past(i_cnt_clk, 2) == '0 |-> $stable(o_cnt_out))
        else $error("channel output moved without count clock or write");
    chk_data_hold: assert property (i_rd_b && $past(i_rd_b) && $past(i_rd_b, 2) |-> $stable(o_data))
        else $error("read byte changed without a read");

    cover property (!o_data_oe_b);
    cover property ($rose(o_cnt_out[1]));
    cover property (!i_cs_b && !i_wr_b && i_port_select_lines == PIT_PORT_CTRL);
endmodule

bind pit_counter_path pit_path_monitor #(.NUM_CH(NUM_CH)) u_pit_path_monitor (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_cs_b(i_cs_b), .i_rd_b(i_rd_b), .i_wr_b(i_wr_b),
    .i_port_select_lines(i_port_select_lines), .o_data(o_data), .o_data_oe_b(o_data_oe_b),
    .i_cnt_clk(i_cnt_clk), .o_cnt_out(o_cnt_out), .o_mode(o_mode)
);
`default_nettype wire

//--- dv/pit_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module pit_host_model (
    input  wire logic       i_clk,
    input  wire logic [7:0] i_bus,
    input  wire logic       i_oe_b,
    output logic            o_cs_b,
    output logic            o_rd_b,
    output logic            o_wr_b,
    output logic            o_drv,
    output logic      [1:0] o_port,
    output logic      [7:0] o_data
);
    initial begin
        {o_cs_b, o_rd_b, o_wr_b, o_drv, o_port, o_data} = 14'h3800;
    end
    // strobe held across the taking edge, then one idle cycle as the gap
    task automatic wr(input logic cs, input logic [1:0] p, input logic [7:0] d);
        @(posedge i_clk);
        {o_cs_b, o_wr_b, o_port, o_data, o_drv} <= {cs, 1'b0, p, d, 1'b1};
        repeat (2) @(posedge i_clk);
        {o_cs_b, o_wr_b, o_drv} <= 3'h6;
        @(posedge i_clk);
    endtask
    task automatic rd(input logic [1:0] p, output logic [7:0] v, output logic oe);
        @(posedge i_clk);
        {o_cs_b, o_rd_b, o_port} <= {2'h0, p};
        repeat (2) @(posedge i_clk);
        #1;
        v = i_bus;
        oe = i_oe_b;
        @(posedge i_clk);
        {o_cs_b, o_rd_b} <= 2'h3;
        @(posedge i_clk);
    endtask
endmodule
`default_nettype wire

//--- dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import pit_pkg::*;
    typedef struct packed {
        logic [1:0] ch;
        logic [1:0] fmt;
        logic [2:0] m;
        logic [7:0] b0;
        logic [7:0] b1;
    } pit_row_t;
    logic            i_clk = 1'b0;
    logic            i_rst_b = 1'b0;
    logic [2:0]      cnt_clk = 3'h0;
    logic [2:0]      gate = 3'h0;
    logic [7:0]      rv;
    logic            roe;
    wire logic       cs_b, rd_b, wr_b, drv, oe_b;
    wire logic [1:0] port;
    wire logic [7:0] hdat, dout, bus;
    wire logic [2:0] outs;
    wire logic [8:0] mode;
    int              mismatches = 0;
    int              n_checks = 0;
    int              cyc = 0;
    pit_row_t        rows [3] = '{'{2'h0, PIT_FMT_LOW, 3'h5, 8'h5a, 8'h00},
                                  '{2'h1, PIT_FMT_HIGH, 3'h6, 8'ha5, 8'h00},
                                  '{2'h2, PIT_FMT_BOTH, 3'h7, 8'h34, 8'h12}};
    // undriven bus shows the inverse of the host's last byte, not a kind constant
    assign bus = !oe_b ? dout : (drv ? hdat : ~hdat);
    always #10 i_clk = ~i_clk;
    pit_counter_path u_pit_counter_path (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_cs_b(cs_b), .i_rd_b(rd_b),
        .i_wr_b(wr_b), .i_port_select_lines(port), .i_data(bus), .o_data(dout), .o_data_oe_b(oe_b),
        .i_cnt_clk(cnt_clk), .i_gate(gate), .o_cnt_out(outs), .o_mode(mode));
    pit_host_model u_pit_host_model (.i_clk(i_clk), .i_bus(bus), .i_oe_b(oe_b), .o_cs_b(cs_b), .o_rd_b(rd_b),
        .o_wr_b(wr_b), .o_drv(drv), .o_port(port), .o_data(hdat));
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            stop_test();
        end
    end
    task automatic check(input string n, input logic [8:0] e, input logic [8:0] g);
        #1;
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rd_chk(input logic [1:0] p, input logic [7:0] e);
        u_pit_host_model.rd(p, rv, roe);
        check("read byte", {1'b0, e}, {1'b0, rv});
    endtask
    task automatic cw(input logic [1:0] ch, input logic [1:0] fmt, input logic [2:0] m);
        u_pit_host_model.wr(1'b0, PIT_PORT_CTRL, {ch, fmt, m, 1'b0});
    endtask
    task automatic wr(input logic [1:0] ch, input logic [7:0] d);
        u_pit_host_model.wr(1'b0, ch, d);
    endtask
    task automatic step(input int c, input int k);
        repeat (k) begin
            @(posedge i_clk);
            cnt_clk[c] <= 1'b1;
            repeat (2) @(posedge i_clk);
            cnt_clk[c] <= 1'b0;
            repeat (2) @(posedge i_clk);
        end
    endtask
    function automatic logic [2:0] exp_mode(input logic [2:0] m);
        return m[1] ? {1'b0, m[1:0]} : m;
    endfunction
    initial begin
        repeat (2) @(posedge i_clk);
        i_rst_b <= 1'b1;
        gate <= 3'h7;
        check("reset outputs", 9'h003, {4'h0, outs, oe_b, dout == 8'h00 && mode == 9'h0});
        for (int m = 0; m < 8; m++) begin
            cw(2'h0, PIT_FMT_LOW, 3'(m));
            check("mode", {6'h0, exp_mode(3'(m))}, {6'h0, mode[2:0]});
        end
        foreach (rows[i]) begin
            cw(rows[i].ch, rows[i].fmt, rows[i].m);
            wr(rows[i].ch, rows[i].b0);
            if (rows[i].fmt == PIT_FMT_BOTH) wr(rows[i].ch, rows[i].b1);
            rd_chk(rows[i].ch, rows[i].b0);
            if (rows[i].fmt == PIT_FMT_BOTH) rd_chk(rows[i].ch, rows[i].b1);
        end
        check("all modes", 9'h0d5, mode);
        u_pit_host_model.wr(1'b1, 2'h0, 8'hee);
        cw(2'h3, 2'h0, 3'h2);
        check("mode after read-back", 9'h0d5, mode);
        rd_chk(2'h0, 8'h5a);
        u_pit_host_model.rd(PIT_PORT_CTRL, rv, roe);
        check("control port read", 9'h001, {8'h0, roe});
        cw(2'h2, PIT_FMT_LOW, 3'h0);
        wr(2'h2, 8'h77);
        cw(2'h2, PIT_FMT_HIGH, 3'h0);
        wr(2'h2, 8'h88);
        rd_chk(2'h2, 8'h88);
        cw(2'h2, PIT_FMT_LOW, 3'h0);
        rd_chk(2'h2, 8'h00);
        cw(2'h0, PIT_FMT_BOTH, 3'h0);
        wr(2'h0, 8'h10);
        wr(2'h0, 8'h00);
        cw(2'h0, PIT_FMT_LATCH, 3'h0);
        step(0, 3);
        cw(2'h0, PIT_FMT_LATCH, 3'h0);
        rd_chk(2'h0, 8'h10);
        rd_chk(2'h0, 8'h00);
        rd_chk(2'h0, 8'h0d);
        rd_chk(2'h0, 8'h00);
        cw(2'h1, PIT_FMT_LOW, 3'h0);
        wr(2'h1, 8'h02);
        repeat (2) @(posedge i_clk);
        check("out after load", 9'h000, {8'h0, outs[1]});
        step(1, 2);
        check("out at zero", 9'h001, {8'h0, outs[1]});
        wr(2'h1, 8'h03);
        check("out after reload", 9'h000, {8'h0, outs[1]});
        // reset again mid-run; the first access after release must still work
        @(posedge i_clk);
        i_rst_b <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst_b <= 1'b1;
        check("mid-run reset", 9'h003, {4'h0, outs, oe_b, dout == 8'h00 && mode == 9'h0});
        cw(2'h1, PIT_FMT_LOW, 3'h4);
        check("mode after reset", 9'h020, mode);
        wr(2'h1, 8'h3c);
        rd_chk(2'h1, 8'h3c);
        stop_test();
    end
endmodule
`default_nettype wire
